// ### hw/edl_pkg.sv
// package: types and constants of the error detect and log block
// Notes on behaviour
// RULE1 - check request/address parity on valid cpu requests; mismatch is fatal
// RULE2 - after request/address parity error still give a normal response
// RULE3 - unsupported request or size: log fatal, no response, no retry (code logs it as fatal for cpu requests only)
// RULE4 - time each deferred transaction; fatal error if no reply in time (code has one timer; a new start restarts it)
// RULE5 - cpu data parity error: log uncorrectable, poison and forward data
// RULE6 - machine check: log uncorrectable, forward to the other bus
// RULE7 - bus init: log, reset arbitration, never forward; software resets
// RULE8 - options bit 5 gates logging of machine check and bus init
// RULE9 - protocol violation: log fatal, answer with implicit writeback
// RULE10 - bus syndrome and failing address kept for the first error only
// RULE11 - illegal source or destination address: own flags, halt engine
// RULE12 - illegal or misaligned next descriptor: own flags, halt engine
// RULE13 - next descriptor error reported only after descriptor completes
// RULE14 - illegal or misaligned chain address: flag and halt
// RULE15 - command write with more than one bit set: flag and halt
// RULE16 - data parity error during descriptor transfer: flag and halt
// RULE17 - read or write that cannot complete: separate flags, halt
// RULE18 - bad control, length, completion address, interrupt setup: halt
// RULE19 - on dma error snapshot channel words into first or next log
// RULE20 - logged source and destination are the runtime addresses
// RULE21 - link protocol error: log header, severity bit, default fatal
// RULE22 - poisoned, unsupported, flow control: severity bits, header log
// RULE23 - fatal message: root port fatal state, first error pointer
// RULE24 - first log holds earliest error until cleared; later go to next
package edl_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_MHZ      = 40;
   localparam int          DEFER_TMO_NS = 10000;
   localparam int          DEFER_CYC    = DEFER_TMO_NS * CLK_MHZ / 1000;
   localparam logic [15:0] DEFER_LAST   = 16'(DEFER_CYC - 1);
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] A_OPT = 8'h00;
   localparam logic [7:0] A_BFF = 8'h04;
   localparam logic [7:0] A_BFN = 8'h08;
   localparam logic [7:0] A_BNF = 8'h0c;
   localparam logic [7:0] A_BNN = 8'h10;
   localparam logic [7:0] A_SYU = 8'h14;
   localparam logic [7:0] A_AHI = 8'h18;
   localparam logic [7:0] A_ALO = 8'h1c;
   localparam logic [7:0] A_SYR = 8'h20;
   localparam logic [7:0] A_CMD = 8'h24;
   localparam logic [7:0] A_CHN = 8'h28;
   localparam logic [7:0] A_DFE = 8'h2c;
   localparam logic [7:0] A_DNE = 8'h30;
   localparam logic [7:0] A_DST = 8'h34;
   localparam logic [7:0] A_SEV = 8'h38;
   localparam logic [7:0] A_UST = 8'h3c;
   localparam logic [7:0] A_AER = 8'h40;
   localparam logic [7:0] A_RPS = 8'h44;
   localparam logic [7:0] A_LFF = 8'h48;
   localparam logic [7:0] A_LFN = 8'h4c;
   localparam logic [7:0] A_LNF = 8'h50;
   localparam logic [7:0] A_LNN = 8'h54;
   localparam logic [7:0] A_HDR = 8'h58;
   localparam logic [2:0] A_SNF = 3'h3;
   localparam logic [2:0] A_SNN = 3'h4;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int OPT_PRST  = 0;
   localparam int OPT_LOG   = 5;
   localparam int BF_PAR    = 0;
   localparam int BF_UNSUP  = 1;
   localparam int BF_DEFER  = 2;
   localparam int BF_PROTO  = 3;
   localparam int BN_DPAR   = 0;
   localparam int BN_MC     = 1;
   localparam int BN_INIT   = 2;
   localparam int CMD_START = 0;
   localparam int CMD_STOP  = 2;
   localparam int CMD_RESET = 5;
   localparam int DE_SRC = 0;
   localparam int DE_DST = 1;
   localparam int DE_NXT = 2;
   localparam int DE_ALN = 3;
   localparam int DE_CHN = 4;
   localparam int DE_CMD = 5;
   localparam int DE_PAR = 6;
   localparam int DE_RD  = 8;
   localparam int DE_WR  = 9;
   localparam int DE_CTL = 10;
   localparam int DE_LEN = 11;
   localparam int DE_CMP = 12;
   localparam int DE_INT = 13;
   localparam int SN_NXT = 6;
   localparam logic [4:0]  LX_DLL  = 5'd4;
   localparam logic [4:0]  LX_FMSG = 5'd5;
   localparam logic [4:0]  LX_POIS = 5'd12;
   localparam logic [4:0]  LX_FC   = 5'd13;
   localparam logic [4:0]  LX_UR   = 5'd20;
   localparam logic [7:0]  RPS_FMSG = 8'h44;
   localparam logic [31:0] OPT_RST = 32'h0000_0000;
   localparam logic [31:0] SEV_RST = 32'h0000_2010;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {RSP_NONE, RSP_NORMAL, RSP_IWB} edl_kind_t;
   typedef enum logic [2:0] {LE_DLL, LE_FMSG, LE_UR, LE_POIS, LE_FC}
      edl_lcode_t;
   typedef struct packed {
      logic        valid, cpu, par_err, unsup, proto;
      logic [15:0] syn;
      logic [39:0] addr;
   } edl_req_t;
   typedef struct packed {
      logic        valid, cpu, par_err;
      logic [31:0] data;
   } edl_data_t;
   typedef struct packed {
      logic      valid;
      edl_kind_t kind;
   } edl_rsp_t;
   typedef struct packed {
      logic        valid, poison;
      logic [31:0] data;
   } edl_fwd_t;
   typedef struct packed {
      logic src, dst, nxt, par, rd, wr, ctl, len, cmp, intr, chn, done;
   } edl_dma_ev_t;
   typedef struct packed {
      logic       valid;
      edl_lcode_t code;
      logic [31:0] hdr;
   } edl_link_ev_t;
   typedef logic [5:0][31:0] edl_snap_t;
   typedef struct packed {
      logic [31:0]      opt, bff, bfn, bnf, bnn, syn_u, ahi, alo, syn_r;
      logic [7:0]       cmd;
      logic [31:0]      chain, dfe, dne;
      logic             run, halt;
      logic [31:0]      sev, ust;
      logic [4:0]       ptr;
      logic [7:0]       rps;
      logic [31:0]      lff, lfn, lnf, lnn, hdr;
      logic [7:0][31:0] snf, snn;
      logic [15:0]      dcnt;
      logic             dact;
      logic [1:0]       mcp, mcf, ip;
      logic             arb, prst;
      edl_rsp_t         rsp;
      edl_fwd_t         fwd;
      logic [31:0]      rdata;
   } edl_st_t;
endpackage

// ### hw/edl_top.sv
// module: error detection, classification and first/next logging
`timescale 1ns/1ps
`default_nettype none
module edl_top import edl_pkg::*; (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic [7:0]   i_addr,
   input  wire logic [31:0]  i_wdata,
   input  wire logic         i_wr,
   input  wire logic         i_rd,
   output logic [31:0]       o_rdata,
   input  wire edl_req_t     i_bus_req,
   input  wire edl_data_t    i_bus_data,
   input  wire logic         i_defer_start,
   input  wire logic         i_defer_reply,
   input  wire logic [1:0]   i_mcheck,
   input  wire logic [1:0]   i_bus_init,
   input  wire edl_dma_ev_t  i_dma_ev,
   input  wire edl_snap_t    i_dma_snap,
   input  wire edl_link_ev_t i_link_ev,
   output edl_rsp_t          o_bus_rsp,
   output edl_fwd_t          o_fwd,
   output logic [1:0]        o_mcheck_fwd,
   output logic              o_arb_reset,
   output logic              o_platform_reset,
   output logic              o_dma_run,
   output logic              o_dma_halted
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [63:0] log_upd(input logic [31:0] f,
                                           input logic [31:0] n,
                                           input logic [31:0] e);
      if (f == '0)
         return {e, n};
      return {f, n | e};
   endfunction

   function automatic logic [4:0] link_idx(input edl_lcode_t c);
      case (c)
         LE_DLL:  return LX_DLL;
         LE_FMSG: return LX_FMSG;
         LE_UR:   return LX_UR;
         LE_POIS: return LX_POIS;
         default: return LX_FC;
      endcase
   endfunction

   edl_st_t          q;
   edl_st_t          d;
   logic [31:0]      bfe;
   logic [31:0]      bne;
   logic [31:0]      dev;
   logic [31:0]      lev;
   logic [31:0]      rd;
   logic [7:0][31:0] snap;
   logic [4:0]       idx;
   logic             cmderr;
   logic             fat;
   logic             mrise;
   logic             irise;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      d        = q;
      d.rsp    = '0;
      d.arb    = 1'b0;
      d.prst   = 1'b0;
      bfe      = '0;
      bne      = '0;
      dev      = '0;
      lev      = '0;
      rd       = '0;
      idx      = '0;
      cmderr   = 1'b0;
      fat      = 1'b0;
      snap[0]  = {30'h0, q.halt, q.run};
      snap[1]  = {24'h0, q.cmd};
      snap[7:2] = i_dma_snap; // RULE20
      // register writes
      if (i_wr) begin
         case (i_addr)
            A_OPT: begin
               d.opt  = i_wdata & ~(32'h1 << OPT_PRST);
               d.prst = i_wdata[OPT_PRST]; // RULE7
            end
            A_BFF: d.bff = q.bff & ~i_wdata;
            A_BFN: d.bfn = q.bfn & ~i_wdata;
            A_BNF: d.bnf = q.bnf & ~i_wdata;
            A_BNN: d.bnn = q.bnn & ~i_wdata;
            A_CMD: begin
               d.cmd = i_wdata[7:0];
               if ($countones(i_wdata[7:0]) > 1)
                  cmderr = 1'b1; // RULE15
               else if (i_wdata[CMD_RESET]) begin
                  d.halt = 1'b0;
                  d.run  = 1'b0;
               end else if (i_wdata[CMD_START])
                  d.run = !q.halt;
               else if (i_wdata[CMD_STOP])
                  d.run = 1'b0;
            end
            A_CHN: begin
               d.chain     = i_wdata;
               dev[DE_CHN] = i_wdata[5:0] != 6'h0; // RULE14
            end
            A_DFE: d.dfe = q.dfe & ~i_wdata;
            A_DNE: d.dne = q.dne & ~i_wdata;
            A_SEV: d.sev = i_wdata;
            A_UST: d.ust = q.ust & ~i_wdata;
            A_RPS: d.rps = q.rps & ~i_wdata[7:0];
            A_LFF: d.lff = q.lff & ~i_wdata;
            A_LFN: d.lfn = q.lfn & ~i_wdata;
            A_LNF: d.lnf = q.lnf & ~i_wdata;
            A_LNN: d.lnn = q.lnn & ~i_wdata;
            default: ;
         endcase
      end
      // ------------------------------------------------------------
      // processor bus
      // ------------------------------------------------------------
      if (i_bus_req.valid) begin
         d.rsp.valid = !i_bus_req.unsup; // RULE3
         if (i_bus_req.unsup)
            d.rsp.kind = RSP_NONE;
         else if (i_bus_req.proto)
            d.rsp.kind = RSP_IWB; // RULE9
         else
            d.rsp.kind = RSP_NORMAL; // RULE2
         if (i_bus_req.cpu) begin
            bfe[BF_PAR]   = i_bus_req.par_err; // RULE1
            bfe[BF_UNSUP] = i_bus_req.unsup; // RULE3
         end
         bfe[BF_PROTO] = i_bus_req.proto; // RULE9
      end
      if (i_defer_start) begin
         d.dact = 1'b1;
         d.dcnt = '0;
      end else if (i_defer_reply)
         d.dact = 1'b0;
      else if (q.dact) begin
         if (q.dcnt == DEFER_LAST) begin
            bfe[BF_DEFER] = 1'b1; // RULE4
            d.dact        = 1'b0;
         end else
            d.dcnt = q.dcnt + 16'h1;
      end
      d.fwd.valid  = i_bus_data.valid;
      d.fwd.data   = i_bus_data.data;
      d.fwd.poison = i_bus_data.valid & i_bus_data.cpu
                     & i_bus_data.par_err; // RULE5
      bne[BN_DPAR] = d.fwd.poison; // RULE5
      d.mcp        = i_mcheck;
      d.ip         = i_bus_init;
      d.mcf        = {i_mcheck[0], i_mcheck[1]}; // RULE6
      mrise        = |(i_mcheck & ~q.mcp);
      irise        = |(i_bus_init & ~q.ip);
      d.arb        = irise; // RULE7
      bne[BN_MC]   = mrise & q.opt[OPT_LOG]; // RULE8
      bne[BN_INIT] = irise & q.opt[OPT_LOG]; // RULE8
      if (d.bff == '0 && bfe != '0) begin
         d.syn_u = {12'h0, bfe[3:0], i_bus_req.syn}; // RULE10
         if (bfe[BF_PAR] | bfe[BF_PROTO]) begin
            d.ahi = {24'h0, i_bus_req.addr[39:32]}; // RULE10
            d.alo = i_bus_req.addr[31:0];
         end
      end
      if (d.bnf == '0 && bne[BN_DPAR])
         d.syn_r = i_bus_data.data; // RULE10
      {d.bff, d.bfn} = log_upd(d.bff, d.bfn, bfe); // RULE24
      {d.bnf, d.bnn} = log_upd(d.bnf, d.bnn, bne); // RULE24
      // ------------------------------------------------------------
      // dma channel
      // ------------------------------------------------------------
      dev[DE_SRC] = i_dma_ev.src; // RULE11
      dev[DE_DST] = i_dma_ev.dst; // RULE11
      dev[DE_NXT] = i_dma_ev.done & i_dma_ev.nxt; // RULE12 RULE13
      dev[DE_ALN] = i_dma_ev.done
                    & (snap[SN_NXT][5:0] != 6'h0); // RULE12 RULE13
      dev[DE_CHN] = dev[DE_CHN] | i_dma_ev.chn; // RULE14
      dev[DE_CMD] = cmderr; // RULE15
      dev[DE_PAR] = i_dma_ev.par; // RULE16
      dev[DE_RD]  = i_dma_ev.rd; // RULE17
      dev[DE_WR]  = i_dma_ev.wr; // RULE17
      dev[DE_CTL] = i_dma_ev.ctl; // RULE18
      dev[DE_LEN] = i_dma_ev.len; // RULE18
      dev[DE_CMP] = i_dma_ev.cmp; // RULE18
      dev[DE_INT] = i_dma_ev.intr; // RULE18
      if (dev != '0) begin
         d.halt = 1'b1; // RULE11
         d.run  = 1'b0;
         if (d.dfe == '0)
            d.snf = snap; // RULE19
         else if (d.dne == '0)
            d.snn = snap; // RULE19
      end
      {d.dfe, d.dne} = log_upd(d.dfe, d.dne, dev); // RULE24
      // ------------------------------------------------------------
      // link root port
      // ------------------------------------------------------------
      if (i_link_ev.valid) begin
         idx = link_idx(i_link_ev.code);
         lev = 32'h1 << idx;
         fat = (i_link_ev.code == LE_FMSG) | q.sev[idx]; // RULE21 RULE22
         if (d.ust == '0)
            d.ptr = idx; // RULE23
         d.ust = d.ust | lev;
         if (i_link_ev.code == LE_FMSG)
            d.rps = d.rps | RPS_FMSG; // RULE23
         if (d.lff == '0 && d.lnf == '0)
            d.hdr = i_link_ev.hdr; // RULE21 RULE22
      end
      {d.lff, d.lfn} = log_upd(d.lff, d.lfn, fat ? lev : '0); // RULE24
      {d.lnf, d.lnn} = log_upd(d.lnf, d.lnn, fat ? '0 : lev);
      // ------------------------------------------------------------
      // register reads
      // ------------------------------------------------------------
      if (i_rd) begin
         case (i_addr)
            A_OPT: rd = q.opt;
            A_BFF: rd = q.bff;
            A_BFN: rd = q.bfn;
            A_BNF: rd = q.bnf;
            A_BNN: rd = q.bnn;
            A_SYU: rd = q.syn_u;
            A_AHI: rd = q.ahi;
            A_ALO: rd = q.alo;
            A_SYR: rd = q.syn_r;
            A_CMD: rd = {24'h0, q.cmd};
            A_CHN: rd = q.chain;
            A_DFE: rd = q.dfe;
            A_DNE: rd = q.dne;
            A_DST: rd = {30'h0, q.halt, q.run};
            A_SEV: rd = q.sev;
            A_UST: rd = q.ust;
            A_AER: rd = {27'h0, q.ptr};
            A_RPS: rd = {24'h0, q.rps};
            A_LFF: rd = q.lff;
            A_LFN: rd = q.lfn;
            A_LNF: rd = q.lnf;
            A_LNN: rd = q.lnn;
            A_HDR: rd = q.hdr;
            default: begin
               if (i_addr[7:5] == A_SNF)
                  rd = q.snf[i_addr[4:2]];
               else if (i_addr[7:5] == A_SNN)
                  rd = q.snn[i_addr[4:2]];
            end
         endcase
      end
      d.rdata = rd;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q     <= '0;
         q.opt <= OPT_RST;
         q.sev <= SEV_RST;
      end else
         q <= d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_rdata          = q.rdata;
   assign o_bus_rsp        = q.rsp;
   assign o_fwd            = q.fwd;
   assign o_mcheck_fwd     = q.mcf;
   assign o_arb_reset      = q.arb;
   assign o_platform_reset = q.prst;
   assign o_dma_run        = q.run;
   assign o_dma_halted     = q.halt;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sequence s_par_req;
      i_bus_req.valid && i_bus_req.cpu && i_bus_req.par_err
      && !i_bus_req.unsup && !i_bus_req.proto;
   endsequence
   sequence s_normal_rsp;
      o_bus_rsp.valid && o_bus_rsp.kind == RSP_NORMAL;
   endsequence
   sequence s_halted;
      o_dma_halted && !o_dma_run;
   endsequence

   a_parity_fatal_log: assert property ( // RULE1
      s_par_req |=> (q.bff[BF_PAR] || q.bfn[BF_PAR]))
      else $error("address parity error not logged");
   a_parity_normal_rsp: assert property ( // RULE2
      s_par_req |=> s_normal_rsp)
      else $error("parity error request lacks normal response");
   a_unsup_no_rsp: assert property ( // RULE3
      i_bus_req.valid && i_bus_req.unsup |=> !o_bus_rsp.valid)
      else $error("unsupported request was answered");
   a_defer_timeout: assert property ( // RULE4
      q.dact && q.dcnt == DEFER_LAST && !i_defer_start && !i_defer_reply
      |=> (q.bff[BF_DEFER] || q.bfn[BF_DEFER]) && !q.dact)
      else $error("deferred time-out not raised");
   a_data_poison: assert property ( // RULE5
      i_bus_data.valid && i_bus_data.cpu && i_bus_data.par_err
      |=> o_fwd.valid && o_fwd.poison
          && (q.bnf[BN_DPAR] || q.bnn[BN_DPAR]))
      else $error("bad data not poisoned");
   a_mcheck_fwd: assert property ( // RULE6
      i_mcheck[0] |=> o_mcheck_fwd[1])
      else $error("machine check not forwarded");
   a_init_arb: assert property ( // RULE7
      |(i_bus_init & ~q.ip) |=> o_arb_reset)
      else $error("bus init did not reset arbitration");
   a_opt_gates_log: assert property ( // RULE8
      !q.opt[OPT_LOG] |=> !$rose(q.bnf[BN_MC]) && !$rose(q.bnn[BN_MC]))
      else $error("machine check logged while disabled");
   a_proto_iwb: assert property ( // RULE9
      i_bus_req.valid && i_bus_req.proto && !i_bus_req.unsup
      |=> o_bus_rsp.valid && o_bus_rsp.kind == RSP_IWB)
      else $error("protocol error without writeback response");
   a_addr_first: assert property ( // RULE10
      q.bff != '0 && !i_wr |=> $stable(q.alo) && $stable(q.syn_u))
      else $error("failing address overwritten");
   a_dma_halt: assert property ( // RULE11
      i_dma_ev.src || i_dma_ev.dst |=> s_halted ##1 o_dma_halted)
      else $error("dma not halted on address error");
   a_next_wait: assert property ( // RULE13
      !i_dma_ev.done |=> !$rose(q.dfe[DE_NXT]) && !$rose(q.dne[DE_NXT]))
      else $error("next descriptor error reported early");
   a_cmd_multi: assert property ( // RULE15
      i_wr && i_addr == A_CMD && $countones(i_wdata[7:0]) > 1
      |=> s_halted and (q.dfe[DE_CMD] || q.dne[DE_CMD]))
      else $error("bad command write not flagged");
   a_link_hdr: assert property ( // RULE21
      i_link_ev.valid && !i_wr && q.lff == '0 && q.lnf == '0
      |=> q.hdr == $past(i_link_ev.hdr))
      else $error("link header not captured");
   a_fmsg_state: assert property ( // RULE23
      i_link_ev.valid && i_link_ev.code == LE_FMSG
      |=> (q.rps & RPS_FMSG) == RPS_FMSG && q.lff != '0)
      else $error("fatal message not logged");
   a_first_hold: assert property ( // RULE24
      q.dfe != '0 && !i_wr |=> $stable(q.dfe) && $stable(q.snf))
      else $error("first dma error log changed");
endmodule // edl_top
`default_nettype wire

// ### bench/edl_far_model.sv
// far side model: bus agents, dma engine events, link partner
`timescale 1ns/1ps
`default_nettype none
module edl_far_model import edl_pkg::*; (
   input  wire logic    i_clk,
   output edl_req_t     o_req,
   output edl_data_t    o_data,
   output logic         o_dstart,
   output logic         o_dreply,
   output logic [1:0]   o_mc,
   output logic [1:0]   o_init,
   output edl_dma_ev_t  o_dma,
   output edl_snap_t    o_snap,
   output edl_link_ev_t o_link
);
   // ------
   // one-cycle pulses (lvl holds levels), addr and data lines scrambled once released
   // ------
   initial begin
      o_req = '0;
      o_data = '0;
      o_dstart = 1'b0;
      o_dreply = 1'b0;
      o_mc = 2'h0;
      o_init = 2'h0;
      o_dma = '0;
      o_link = '0;
      for (int w = 0; w < 6; w++) begin
         o_snap[w] = 32'h0000_1000 + 32'(w * 64);
      end
   end
   task automatic idle;
      @(posedge i_clk);
      o_req.valid <= 1'b0;
      o_req.addr <= ~o_req.addr;
      o_data.valid <= 1'b0;
      o_data.data <= ~o_data.data;
      o_dma <= '0;
      o_link.valid <= 1'b0;
      o_dstart <= 1'b0;
      o_dreply <= 1'b0;
   endtask
   task automatic rply;
      @(posedge i_clk);
      o_dreply <= 1'b1;
      idle();
   endtask
   task automatic req(input logic [2:0] k, input logic [15:0] s);
      @(posedge i_clk);
      o_req <= '{1'b1, 1'b1, k[2], k[1], k[0], s, {24'h0, s}};
      idle();
   endtask
   task automatic dat(input logic p, input logic [31:0] d);
      @(posedge i_clk);
      o_data <= '{1'b1, 1'b1, p, d};
      idle();
   endtask
   task automatic dma(input edl_dma_ev_t e);
      @(posedge i_clk);
      o_dma <= e;
      idle();
   endtask
   task automatic lnk(input edl_lcode_t c, input logic [31:0] h);
      @(posedge i_clk);
      o_link <= '{1'b1, c, h};
      idle();
   endtask
   task automatic defer;
      @(posedge i_clk);
      o_dstart <= 1'b1;
      idle();
   endtask
   task automatic lvl(input logic [1:0] m, input logic [1:0] b);
      @(posedge i_clk);
      o_mc <= m;
      o_init <= b;
   endtask
endmodule // edl_far_model
`default_nettype wire

// ### bench/tb_top.sv
// testbench: register and event scenarios for the error logger
`timescale 1ns/1ps
`default_nettype none
module tb_top import edl_pkg::*;;
   logic         clk, srst, wr, rd, dstart, dreply, arb, prst, run, halt;
   logic [7:0]   addr;
   logic [31:0]  wdata, rdata;
   logic [1:0]   mc, binit, mcf;
   edl_req_t     req;
   edl_data_t    dat;
   edl_dma_ev_t  dev;
   edl_snap_t    snap;
   edl_link_ev_t lev;
   edl_rsp_t     rsp;
   edl_fwd_t     fwd;
   int           error_cnt, samples_checked;
   logic [11:0]  evs [10] = '{12'h800, 12'h400, 12'h100, 12'h080, 12'h040,
                              12'h020, 12'h010, 12'h008, 12'h004, 12'h002};
   int           bits [10] = '{0, 1, 6, 8, 9, 10, 11, 12, 13, 4};
   edl_far_model edl_far_model_i (.i_clk(clk), .o_req(req), .o_data(dat),
      .o_dstart(dstart), .o_dreply(dreply), .o_mc(mc), .o_init(binit),
      .o_dma(dev), .o_snap(snap), .o_link(lev));
   edl_top edl_top_i (.i_clk(clk), .i_srst(srst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_bus_req(req), .i_bus_data(dat), .i_defer_start(dstart),
      .i_defer_reply(dreply), .i_mcheck(mc), .i_bus_init(binit),
      .i_dma_ev(dev), .i_dma_snap(snap), .i_link_ev(lev),
      .o_bus_rsp(rsp), .o_fwd(fwd), .o_mcheck_fwd(mcf), .o_arb_reset(arb),
      .o_platform_reset(prst), .o_dma_run(run), .o_dma_halted(halt));
   // ------
   // helpers
   // ------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic pulse_chk(input logic sel);
      logic seen;
      seen = 1'b0;
      repeat (3) begin
         #1 seen = seen | (sel ? prst : arb);
         @(posedge clk);
      end
      chk({31'h0, seen}, 32'h1);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end
   // ------
   // scenarios
   // ------
   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd_chk(A_OPT, OPT_RST);
      rd_chk(A_SEV, SEV_RST);
      rd_chk(8'hfc, 32'h0);
      edl_far_model_i.req(3'b100, 16'h5a5a);
      #1 chk(32'(rsp), {29'h0, 1'b1, RSP_NORMAL});
      rd_chk(A_BFF, 32'h1);
      edl_far_model_i.req(3'b001, 16'h1234);
      #1 chk(32'(rsp), {29'h0, 1'b1, RSP_IWB});
      edl_far_model_i.req(3'b010, 16'h4321);
      #1 chk(32'(rsp), 32'h0);
      rd_chk(A_BFN, 32'ha);
      rd_chk(A_SYU, 32'h0001_5a5a);
      rd_chk(A_ALO, 32'h0000_5a5a);
      edl_far_model_i.dat(1'b1, 32'hcafe_f00d);
      #1 chk({30'h0, fwd.valid, fwd.poison}, 32'h3);
      chk(fwd.data, 32'hcafe_f00d);
      rd_chk(A_BNF, 32'h1);
      edl_far_model_i.lvl(2'b01, 2'b00);
      @(posedge clk);
      #1 chk(32'(mcf), 32'h2);
      rd_chk(A_BNN, 32'h0);
      wr_reg(A_OPT, 32'h20);
      edl_far_model_i.lvl(2'b00, 2'b01);
      pulse_chk(1'b0);
      chk(32'(mcf), 32'h0);
      rd_chk(A_BNN, 32'h4);
      wr_reg(A_OPT, 32'h21);
      pulse_chk(1'b1);
      wr_reg(A_BFF, 32'hf);
      wr_reg(A_BFN, 32'hf);
      edl_far_model_i.defer();
      repeat (393) @(posedge clk);
      rd_chk(A_BFF, 32'h0);
      repeat (8) @(posedge clk);
      rd_chk(A_BFF, 32'h4);
      wr_reg(A_BFF, 32'hf);
      edl_far_model_i.defer();
      edl_far_model_i.rply();
      repeat (400) @(posedge clk);
      rd_chk(A_BFF, 32'h0);
      for (int i = 0; i < 10; i++) begin
         wr_reg(A_DFE, 32'hffff);
         wr_reg(A_CMD, 32'h20);
         wr_reg(A_CMD, 32'h1);
         edl_far_model_i.dma(evs[i]);
         rd_chk(A_DFE, 32'h1 << bits[i]);
         chk({30'h0, halt, run}, 32'h2);
      end
      rd_chk(8'h64, 32'h1);
      rd_chk(8'h6c, 32'h0000_1040);
      wr_reg(A_DFE, 32'hffff);
      wr_reg(A_CMD, 32'h20);
      wr_reg(A_CMD, 32'h1);
      @(posedge clk);
      #1 chk({30'h0, halt, run}, 32'h1);
      wr_reg(A_CMD, 32'h5);
      rd_chk(A_DFE, 32'h20);
      chk({30'h0, halt, run}, 32'h2);
      wr_reg(A_DNE, 32'hffff);
      wr_reg(A_CMD, 32'h20);
      wr_reg(A_CMD, 32'h1);
      edl_far_model_i.dma(12'h200);
      rd_chk(A_DNE, 32'h0);
      chk({31'h0, halt}, 32'h0);
      edl_far_model_i.dma(12'h201);
      rd_chk(A_DNE, 32'h4);
      wr_reg(A_CHN, 32'h44);
      rd_chk(A_DNE, 32'h14);
      edl_far_model_i.lnk(LE_POIS, 32'hab);
      rd_chk(A_UST, 32'h1000);
      rd_chk(A_AER, 32'hc);
      rd_chk(A_HDR, 32'hab);
      edl_far_model_i.lnk(LE_FMSG, 32'hcd);
      rd_chk(A_RPS, 32'h44);
      rd_chk(A_AER, 32'hc);
      edl_far_model_i.lnk(LE_DLL, 32'h1);
      edl_far_model_i.lnk(LE_UR, 32'h2);
      edl_far_model_i.lnk(LE_FC, 32'h3);
      rd_chk(A_UST, 32'h0010_3030);
      rd_chk(A_LFF, 32'h20);
      rd_chk(A_LNN, 32'h0010_0000);
      wr_reg(A_SEV, 32'h0010_0000);
      edl_far_model_i.lnk(LE_UR, 32'h4);
      rd_chk(A_LFN, 32'h0010_2010);
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
